/* include/ssi_pkg.sv */
// Constants, register map and state encoding of the motor start sequencer.
package ssi_pkg;

	// ==========================================
	// Clock and time bases
	localparam int unsigned CLK_KHZ       = 100_000;
	localparam int unsigned ALIGN_BASE_MS = 40;
	localparam int unsigned ALIGN_CYC     = ALIGN_BASE_MS * CLK_KHZ;
	localparam int unsigned BRAKE_BASE_MS = 10;
	localparam int unsigned BRAKE_CYC     = BRAKE_BASE_MS * CLK_KHZ;
	localparam int unsigned PROBE_GAP_US  = 100;
	localparam int unsigned PROBE_GAP_CYC = PROBE_GAP_US * CLK_KHZ / 1000;
	localparam int unsigned ACC_TICK_MS   = 1;
	localparam int unsigned ACC_TICK_CYC  = ACC_TICK_MS * CLK_KHZ;
	localparam logic [11:0] PROBE_TMO     = 12'hFFF;
	// Commutation accumulator wraps after six periods of the rate in speed_reg, at 1 uHz units.
	localparam logic [49:0] COMM_WRAP     = 50'(64'd6 * 64'(CLK_KHZ) * 64'd1000 * 64'd1000000);
	localparam logic [31:0] UHZ_PER_DHZ   = 32'h0001_86A0;

	// ==========================================
	// Register map and reset values
	localparam logic [3:0]  ADR_CFG0  = 4'h0;
	localparam logic [3:0]  ADR_CFG1  = 4'h4;
	localparam logic [3:0]  ADR_CFG2  = 4'h8;
	localparam logic [3:0]  ADR_STAT  = 4'hC;
	localparam logic [31:0] CFG0_RST  = 32'h0000_0000;
	localparam logic [31:0] CFG1_RST  = 32'h0000_0000;
	localparam logic [31:0] CFG2_RST  = 32'h0000_0000;
	localparam int unsigned RUN_BIT   = 31;

	// ==========================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_START  = 3'b000,
		ST_BRAKE  = 3'b001,
		ST_PROBE  = 3'b010,
		ST_ALIGN  = 3'b011,
		ST_ACCEL  = 3'b100,
		ST_CLOSED = 3'b101
	} ssi_state_t;

endpackage : ssi_pkg

/* rtl/ssi_start_seq.sv */
// Start-up sequencer: brake, align, inductive position probe and open-loop acceleration.
// Functional notes
// - Brake turns all three low-side switches on together.
// - Brake is used only when the brake hold time selection is non-zero.
// - Brake ends after current stays below exit threshold for the hold time.
// - With brake enabled, brake precedes probe or align, then start as stationary.
// - With brake disabled, skip brake and start as if stationary.
// - Align drives dc current into V and out of W for selected time.
// - Position probe is enabled when its current limit field is non-zero.
// - Probe pulses follow the order VW, WV, UV, VU, WU, UW.
// - Each pulse ends at current threshold; its rise time is recorded.
// - The pattern with the shortest rise time is the rotor position.
// - Release 0 keeps low side on; release 1 turns all switches off.
// - Driving starts at the detected position plus the selected angle offset.
// - Open loop drives at the selected current and raises commutation rate.
// - Acceleration uses first and second order coefficients until handoff.
// - Five-bit handoff threshold spans 0.8 Hz to 204.8 Hz.
// - After brake or its bypass, probe if enabled, otherwise align.
// - After align or probe, go to open-loop acceleration.
// - Leave acceleration for closed loop once rate exceeds the threshold.
// - A direction pin change during start stops drive and restarts.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps

module ssi_start_seq import ssi_pkg::*; #(
	parameter int unsigned ALIGN_BASE = ALIGN_CYC,
	parameter int unsigned BRAKE_BASE = BRAKE_CYC,
	parameter int unsigned PROBE_GAP  = PROBE_GAP_CYC,
	parameter int unsigned ACC_TICK   = ACC_TICK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	input  wire logic        dirPin,
	input  wire logic        brakeCurLowPin,
	input  wire logic        probeHitPin,
	output logic      [2:0]  highSideOn,
	output logic      [2:0]  lowSideOn,
	output logic      [1:0]  driveLevel,
	output logic      [2:0]  brakeExitCurrent,
	output logic      [3:0]  probeCurrentLimit,
	output logic      [2:0]  seqState
);

	// ==========================================
	// Helper functions
	// Gate pattern {high, low} of a phase pair, bit 0 is U, bit 2 is W.
	function automatic logic [5:0] pairGates(input logic [2:0] idx);
		case (idx)
			3'h0: pairGates = {3'h2, 3'h4};
			3'h1: pairGates = {3'h4, 3'h2};
			3'h2: pairGates = {3'h1, 3'h2};
			3'h3: pairGates = {3'h2, 3'h1};
			3'h4: pairGates = {3'h4, 3'h1};
			3'h5: pairGates = {3'h1, 3'h4};
			default: pairGates = 6'h00;
		endcase
	endfunction : pairGates

	// Next pattern index, wrapping after the sixth.
	function automatic logic [2:0] nextIdx(input logic [2:0] idx);
		nextIdx = (idx == 3'h5) ? 3'h0 : idx + 3'h1;
	endfunction : nextIdx

	// First-order acceleration per tick, in uHz per ms, one entry per linear coefficient code.
	localparam logic [31:0] LIN_STEP [8] = '{32'h0000_0013, 32'h0000_0042, 32'h0000_00E6, 32'h0000_0320,
		32'h0000_0AE6, 32'h0000_25E4, 32'h0000_8408, 32'h0001_28E0};

	// ==========================================
	// State
	logic [31:0] cfg0_reg, cfg0_next, cfg1_reg, cfg1_next, cfg2_reg, cfg2_next, rdata_reg, rdata_next;
	logic [2:0]  meta_reg, sync_reg, hs_reg, hs_next, ls_reg, ls_next;
	logic        dirPrev_reg, dirPrev_next, pulse_reg, pulse_next;
	ssi_state_t  state_reg, state_next;
	logic [2:0]  pidx_reg, pidx_next, best_reg, best_next, drv_reg, drv_next;
	logic [11:0] bestT_reg, bestT_next;
	logic [31:0] speed_reg, speed_next, rateX_reg, rateX_next, tmr_reg, tmr_next, tickCnt_reg, tickCnt_next;
	logic [49:0] comm_reg, comm_next;
	logic [1:0]  lvl_reg, lvl_next;

	// Configuration fields.
	logic [2:0]  brakeHoldSel, alignSel, accelLinSel, accelQuadSel, brakeCurSel;
	logic [1:0]  openLoopCurSel, pulseRateSel, angleOffsetSel;
	logic [3:0]  probeLimit;
	logic        releaseSel, runEn, dirChange;
	logic [4:0]  handoffSel;
	logic [31:0] brakeLim, alignLim, gapLim, handoffUhz;

	assign brakeHoldSel   = cfg0_reg[2:0];
	assign brakeCurSel    = cfg0_reg[6:4];
	assign alignSel       = cfg0_reg[10:8];
	assign openLoopCurSel = cfg0_reg[13:12];
	assign runEn          = cfg0_reg[RUN_BIT];
	assign probeLimit     = cfg1_reg[3:0];
	assign releaseSel     = cfg1_reg[4];
	assign pulseRateSel   = cfg1_reg[7:6];
	assign angleOffsetSel = cfg1_reg[9:8];
	assign handoffSel     = cfg1_reg[20:16];
	assign accelLinSel    = cfg2_reg[2:0];
	assign accelQuadSel   = cfg2_reg[6:4];
	// Limits derived from the selections.
	assign brakeLim   = 32'(BRAKE_BASE) * 32'(brakeHoldSel);
	assign alignLim   = 32'(ALIGN_BASE) << alignSel;
	assign gapLim     = 32'(PROBE_GAP) << pulseRateSel;
	assign handoffUhz = (32'h0000_0008 + 32'(handoffSel) * 32'h0000_07F8 / 32'h0000_001F) * UHZ_PER_DHZ;
	assign dirChange  = sync_reg[0] != dirPrev_reg;

	// ==========================================
	// Register bus and pin synchronisers: next values.
	always_comb begin
		cfg0_next  = cfg0_reg;
		cfg1_next  = cfg1_reg;
		cfg2_next  = cfg2_reg;
		rdata_next = 32'h0000_0000;
		if (regWr) begin
			case (regAddr)
				ADR_CFG0: cfg0_next = regWdata;
				ADR_CFG1: cfg1_next = regWdata;
				ADR_CFG2: cfg2_next = regWdata;
				default: ;
			endcase
		end
		if (regRd) begin
			case (regAddr)
				ADR_CFG0: rdata_next = cfg0_reg;
				ADR_CFG1: rdata_next = cfg1_reg;
				ADR_CFG2: rdata_next = cfg2_reg;
				ADR_STAT: rdata_next = {speed_reg[31:12], 1'b0, drv_reg, 1'b0, best_reg, 1'b0, state_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		dirPrev_next = sync_reg[0];
	end

	// ==========================================
	// Sequencer: next values.
	always_comb begin
		state_next   = state_reg;
		tmr_next     = tmr_reg + 32'h1;
		pidx_next    = pidx_reg;
		best_next    = best_reg;
		bestT_next   = bestT_reg;
		pulse_next   = pulse_reg;
		drv_next     = drv_reg;
		speed_next   = speed_reg;
		rateX_next   = rateX_reg;
		comm_next    = comm_reg;
		tickCnt_next = tickCnt_reg;
		hs_next      = 3'h0;
		ls_next      = 3'h0;
		lvl_next     = 2'h0;
		case (state_reg)
			ST_START: begin
				tmr_next   = 32'h0;
				pidx_next  = 3'h0;
				bestT_next = PROBE_TMO;
				best_next  = 3'h0;
				pulse_next = 1'b1;
				speed_next = 32'h0;
				rateX_next = 32'h0;
				comm_next  = 50'h0;
				if (runEn && brakeHoldSel != 3'h0)
					state_next = ST_BRAKE;
				else if (runEn && probeLimit != 4'h0)
					state_next = ST_PROBE;
				else if (runEn)
					state_next = ST_ALIGN;
			end
			ST_BRAKE: begin
				ls_next = 3'h7;
				if (!sync_reg[1])
					tmr_next = 32'h0;
				else if (tmr_reg >= brakeLim) begin
					tmr_next   = 32'h0;
					state_next = (probeLimit != 4'h0) ? ST_PROBE : ST_ALIGN;
				end
			end
			ST_PROBE: begin
				if (pulse_reg) begin
					{hs_next, ls_next} = pairGates(pidx_reg);
					if (sync_reg[2] || tmr_reg[11:0] == PROBE_TMO) begin
						{hs_next, ls_next} = releaseSel ? 6'h00 : (pairGates(pidx_reg) & 6'h07);
						pulse_next = 1'b0;
						tmr_next   = 32'h0;
						if (tmr_reg[11:0] < bestT_reg) begin
							bestT_next = tmr_reg[11:0];
							best_next  = pidx_reg;
						end
					end
				end else begin
					ls_next = releaseSel ? 3'h0 : 3'(pairGates(pidx_reg) & 6'h07);
					if (tmr_reg >= gapLim) begin
						tmr_next   = 32'h0;
						pulse_next = 1'b1;
						pidx_next  = nextIdx(pidx_reg);
						if (pidx_reg == 3'h5) begin
							state_next = ST_ACCEL;
							drv_next   = 3'((4'(best_reg) + 4'(angleOffsetSel)) % 4'h6);
						end
					end
				end
			end
			ST_ALIGN: begin
				{hs_next, ls_next} = pairGates(3'h0);
				lvl_next = openLoopCurSel;
				if (tmr_reg >= alignLim) begin
					state_next = ST_ACCEL;
					drv_next   = 3'h1;
				end
			end
			ST_ACCEL, ST_CLOSED: begin
				{hs_next, ls_next} = pairGates(drv_reg);
				lvl_next  = openLoopCurSel;
				comm_next = comm_reg + 50'(speed_reg);
				if (comm_next >= COMM_WRAP) begin
					comm_next = comm_next - COMM_WRAP;
					drv_next  = nextIdx(drv_reg);
				end
				if (state_reg == ST_ACCEL) begin
					tickCnt_next = tickCnt_reg + 32'h1;
					if (tickCnt_reg >= 32'(ACC_TICK) - 32'h1) begin
						tickCnt_next = 32'h0;
						rateX_next   = rateX_reg + (32'h1 << {accelQuadSel, 1'b0});
						speed_next   = speed_reg + LIN_STEP[accelLinSel] + rateX_reg;
					end
					if (speed_reg > handoffUhz)
						state_next = ST_CLOSED;
				end
			end
			default: state_next = ST_START;
		endcase
		if (dirChange || !runEn) begin
			state_next         = ST_START;
			{hs_next, ls_next} = 6'h00;
			lvl_next           = 2'h0;
		end
	end

	// ==========================================
	// All registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg0_reg    <= CFG0_RST;
			cfg1_reg    <= CFG1_RST;
			cfg2_reg    <= CFG2_RST;
			rdata_reg   <= 32'h0;
			meta_reg    <= 3'h0;
			sync_reg    <= 3'h0;
			dirPrev_reg <= 1'b0;
			state_reg   <= ST_START;
			tmr_reg     <= 32'h0;
			pidx_reg    <= 3'h0;
			best_reg    <= 3'h0;
			bestT_reg   <= PROBE_TMO;
			pulse_reg   <= 1'b1;
			drv_reg     <= 3'h0;
			speed_reg   <= 32'h0;
			rateX_reg   <= 32'h0;
			comm_reg    <= 50'h0;
			tickCnt_reg <= 32'h0;
			hs_reg      <= 3'h0;
			ls_reg      <= 3'h0;
			lvl_reg     <= 2'h0;
		end else begin
			cfg0_reg    <= cfg0_next;
			cfg1_reg    <= cfg1_next;
			cfg2_reg    <= cfg2_next;
			rdata_reg   <= rdata_next;
			meta_reg    <= {probeHitPin, brakeCurLowPin, dirPin};
			sync_reg    <= meta_reg;
			dirPrev_reg <= dirPrev_next;
			state_reg   <= state_next;
			tmr_reg     <= tmr_next;
			pidx_reg    <= pidx_next;
			best_reg    <= best_next;
			bestT_reg   <= bestT_next;
			pulse_reg   <= pulse_next;
			drv_reg     <= drv_next;
			speed_reg   <= speed_next;
			rateX_reg   <= rateX_next;
			comm_reg    <= comm_next;
			tickCnt_reg <= tickCnt_next;
			hs_reg      <= hs_next;
			ls_reg      <= ls_next;
			lvl_reg     <= lvl_next;
		end
	end

	// Outputs straight from flip-flops.
	assign regRdata          = rdata_reg;
	assign highSideOn        = hs_reg;
	assign lowSideOn         = ls_reg;
	assign driveLevel        = lvl_reg;
	assign brakeExitCurrent  = brakeCurSel;
	assign probeCurrentLimit = probeLimit;
	assign seqState          = state_reg;

	// ==========================================
	// Assertions and covers
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_BRAKE_LOW: assert property (state_reg == ST_BRAKE && !dirChange && runEn |=> ls_reg == 3'h7 && hs_reg == 3'h0)
		else $error("Brake did not turn on all low sides.");
	AST_BRAKE_EN: assert property (state_reg == ST_START && brakeHoldSel == 3'h0 |=> state_reg != ST_BRAKE)
		else $error("Brake entered with hold time zero.");
	AST_BRAKE_EXIT: assert property ($past(state_reg) == ST_BRAKE && state_reg inside {ST_PROBE, ST_ALIGN}
		|-> $past(tmr_reg) >= $past(brakeLim) && $past(sync_reg[1]))
		else $error("Brake left before hold time.");
	AST_AFTER_BRAKE: assert property ($past(state_reg) == ST_BRAKE && state_reg != ST_BRAKE && state_reg != ST_START
		|-> (state_reg == ST_PROBE) == ($past(probeLimit) != 4'h0))
		else $error("Wrong step after brake.");
	AST_ALIGN_VW: assert property (state_reg == ST_ALIGN && !dirChange && runEn |=> hs_reg == 3'h2 && ls_reg == 3'h4)
		else $error("Align pattern wrong.");
	AST_PROBE_ORDER: assert property (state_reg == ST_PROBE && !pulse_reg && tmr_reg >= gapLim && pidx_reg != 3'h5
		&& !dirChange && runEn |=> pulse_reg && pidx_reg == $past(pidx_reg) + 3'h1)
		else $error("Probe order broken.");
	AST_PROBE_ANGLE: assert property ($past(state_reg) == ST_PROBE && state_reg == ST_ACCEL
		|-> drv_reg == 3'((4'(best_reg) + 4'(angleOffsetSel)) % 4'h6))
		else $error("Drive angle not offset from position.");
	AST_HANDOFF: assert property (state_reg == ST_ACCEL && speed_reg > handoffUhz && !dirChange && runEn
		|=> state_reg == ST_CLOSED)
		else $error("Handoff missed.");
	AST_DIR_RESTART: assert property (dirChange && state_reg != ST_START |=> state_reg == ST_START
		##1 hs_reg == 3'h0 && ls_reg == 3'h0)
		else $error("Direction change did not restart.");
	AST_HIZ_RELEASE: assert property (state_reg == ST_PROBE && !pulse_reg && releaseSel && !dirChange && runEn
		|=> hs_reg == 3'h0 && ls_reg == 3'h0)
		else $error("High impedance release drove a switch.");

	COV_BRAKE_PROBE: cover property (state_reg == ST_BRAKE ##1 state_reg == ST_PROBE);
	COV_PROBE_ACCEL: cover property (state_reg == ST_PROBE ##1 state_reg == ST_ACCEL);
	COV_ALIGN_ACCEL: cover property (state_reg == ST_ALIGN ##1 state_reg == ST_ACCEL);
	COV_CLOSED:      cover property (state_reg == ST_ACCEL ##1 state_reg == ST_CLOSED);

endmodule : ssi_start_seq

/* sim/ssi_motor_model.sv */
// Behavioural model of the motor windings and the two current comparators.
`timescale 1ns/100ps

module ssi_motor_model #(
	parameter int unsigned BRAKE_DECAY = 30
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  highSideOn,
	input  wire logic [2:0]  lowSideOn,
	input  wire logic [11:0] riseDly [6],
	input  wire logic        curSpike,
	output logic             brakeCurLowPin,
	output logic             probeHitPin
);
	// ==========================================
	// Winding current
	localparam logic [5:0] PAIR [6] = '{6'h14, 6'h22, 6'h0A, 6'h11, 6'h21, 6'h0C};
	int unsigned brakeCnt;
	int unsigned riseCnt;
	logic [11:0] dly;

	// Rise time depends on which phase pair is driven; any other drive gives no pulse.
	always_comb begin
		dly = 12'hFFF;
		for (int i = 0; i < 6; i++) begin
			if ({highSideOn, lowSideOn} == PAIR[i]) begin
				dly = riseDly[i];
			end
		end
	end

	// Current decays while all low sides short the windings; a spike restarts the decay.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			brakeCnt <= 0;
			riseCnt <= 0;
		end else begin
			brakeCnt <= (lowSideOn == 3'h7 && highSideOn == 3'h0 && !curSpike) ? brakeCnt + 1 : 0;
			riseCnt <= (dly != 12'hFFF) ? riseCnt + 1 : 0;
		end
	end

	assign brakeCurLowPin = (brakeCnt >= BRAKE_DECAY) && !curSpike;
	assign probeHitPin = (dly != 12'hFFF) && (riseCnt >= dly);

endmodule : ssi_motor_model

/* sim/tb.sv */
// Self-checking testbench of the motor start sequencer.
`timescale 1ns/100ps

module tb import ssi_pkg::*;;
	// ==========================================
	// Signals and instances
	localparam int unsigned AB = 50;
	localparam int unsigned BB = 20;
	// Cycles the model needs before its low-current comparator rises again after a spike.
	localparam int unsigned DEC = 30;
	localparam logic [5:0] PAIR [6] = '{6'h14, 6'h22, 6'h0A, 6'h11, 6'h21, 6'h0C};
	logic        clk, rstn, regWr, regRd, dirPin, curSpike, brakeCurLowPin, probeHitPin;
	logic [3:0]  regAddr, probeCurrentLimit;
	logic [31:0] regWdata, regRdata, lfsrState, d;
	logic [2:0]  highSideOn, lowSideOn, brakeExitCurrent, seqState;
	logic [1:0]  driveLevel;
	logic [11:0] riseDly [6];
	logic [5:0]  prevG;
	logic [5:0]  gq [$];
	int unsigned n_mismatch, n_tests, cycles, n, best, bsel, off, rel, rate;

	ssi_start_seq #(.ALIGN_BASE(AB), .BRAKE_BASE(BB), .PROBE_GAP(8), .ACC_TICK(4)) u_ssi_start_seq (
		.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .dirPin(dirPin), .brakeCurLowPin(brakeCurLowPin), .probeHitPin(probeHitPin),
		.highSideOn(highSideOn), .lowSideOn(lowSideOn), .driveLevel(driveLevel),
		.brakeExitCurrent(brakeExitCurrent), .probeCurrentLimit(probeCurrentLimit), .seqState(seqState));

	ssi_motor_model #(.BRAKE_DECAY(DEC)) u_ssi_motor_model (
		.clk(clk), .rstn(rstn), .highSideOn(highSideOn), .lowSideOn(lowSideOn), .riseDly(riseDly),
		.curSpike(curSpike), .brakeCurLowPin(brakeCurLowPin), .probeHitPin(probeHitPin));

	// Clock at 100 MHz.
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// A hang is cut short well above the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Gate changes seen while probing are kept in order.
	always @(posedge clk) begin
		if (seqState === ST_PROBE && {highSideOn, lowSideOn} !== prevG) begin
			gq.push_back({highSideOn, lowSideOn});
		end
		prevG <= {highSideOn, lowSideOn};
	end

	// ==========================================
	// Helpers
	function automatic int unsigned rnd(input int unsigned m);
		lfsrState = lfsrState[0] ? (lfsrState >> 1) ^ 32'h8020_0003 : lfsrState >> 1;
		return lfsrState % m;
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		// One idle edge lets the write land and keeps the strobe from being set twice in one step.
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
		@(posedge clk);
	endtask : rd

	task automatic wait_st(input logic [2:0] s, input int unsigned maxc);
		n = 0;
		while (seqState !== s && n < maxc) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_st

	task tally_and_finish;
		$display("TB: comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================
	// Main sequence
	initial begin
		{rstn, regWr, regRd, regAddr, regWdata, dirPin, curSpike} = '0;
		{cycles, n_mismatch, n_tests} = '0;
		lfsrState = 32'h3897;
		prevG = 6'h00;
		for (int i = 0; i < 6; i++) riseDly[i] = 12'h020;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("gates at reset", {highSideOn, lowSideOn, driveLevel}, 32'h0);
		for (int a = 0; a < 16; a += 4) begin
			rd(4'(a), d);
			chk("register reset", d, 32'h0);
		end
		rd(4'h2, d);
		chk("unmapped read", d, 32'h0);
		wr(ADR_STAT, 32'hFFFF_FFFF);
		rd(ADR_STAT, d);
		chk("status write ignored", d, 32'h0);
		// Align path with brake and probe both off.
		wr(ADR_CFG2, 32'h0000_0077);
		wr(ADR_CFG1, 32'h0);
		wr(ADR_CFG0, 32'h0000_2150);
		rd(ADR_CFG2, d);
		chk("coef readback", d, 32'h0000_0077);
		rd(ADR_CFG0, d);
		chk("cfg readback", d, 32'h0000_2150);
		chk("exit current out", brakeExitCurrent, 32'h5);
		wr(ADR_CFG0, 32'h8000_2150);
		wait_st(ST_ALIGN, 5);
		chk("align entered", seqState, ST_ALIGN);
		repeat (2) @(posedge clk);
		chk("align gates", {highSideOn, lowSideOn}, 32'h14);
		chk("align level", driveLevel, 32'h2);
		wait_st(ST_ACCEL, 1000);
		chk("align time", n >= AB * 2 - 6 && n <= AB * 2 + 4, 32'h1);
		chk("accel after align", seqState, ST_ACCEL);
		repeat (2) @(posedge clk);
		chk("accel level", driveLevel, 32'h2);
		wait_st(ST_CLOSED, 40000);
		chk("handoff", seqState, ST_CLOSED);
		wr(ADR_CFG0, 32'h0);
		wait_st(ST_START, 4);
		// Brake then probe, random settings with release alternating per run, first run with equal rise times.
		for (int r = 0; r < 4; r++) begin
			best = 0;
			for (int i = 0; i < 6; i++) begin
				if (r > 0) riseDly[i] = 12'(20 + rnd(150));
				if (riseDly[i] < riseDly[best]) best = i;
			end
			bsel = 1 + rnd(7);
			off = rnd(4);
			rel = r % 2;
			rate = rnd(4);
			gq.delete();
			wr(ADR_CFG1, 32'((off << 8) | (rate << 6) | (rel << 4) | 5));
			chk("probe limit out", probeCurrentLimit, 32'h5);
			wr(ADR_CFG0, 32'(32'h8000_1000 | bsel));
			wait_st(ST_BRAKE, 5);
			chk("brake entered", seqState, ST_BRAKE);
			repeat (2) @(posedge clk);
			chk("brake gates", {highSideOn, lowSideOn}, 32'h07);
			repeat (38) @(posedge clk);
			curSpike <= 1'b1;
			@(posedge clk);
			curSpike <= 1'b0;
			wait_st(ST_PROBE, 400);
			// The hold count starts only once the decayed current has passed the two-stage synchroniser.
			chk("brake hold", n >= BB * bsel + DEC && n <= BB * bsel + DEC + 6, 32'h1);
			chk("probe after brake", seqState, ST_PROBE);
			wait_st(ST_ACCEL, 20000);
			chk("accel after probe", seqState, ST_ACCEL);
			rd(ADR_STAT, d);
			chk("best pattern", d[6:4], 32'(best));
			chk("drive start", d[10:8], 32'((best + off) % 6));
			chk("pulse count", gq.size(), 32'd12);
			for (int i = 0; i < 6 && gq.size() == 12; i++) begin
				chk("pulse pattern", gq[2 * i], PAIR[i]);
				chk("release", gq[2 * i + 1], rel ? 32'h0 : {29'h0, PAIR[i][2:0]});
			end
			if (r == 3) begin
				dirPin <= ~dirPin;
				wait_st(ST_START, 6);
				chk("direction restart", seqState, ST_START);
			end
			wr(ADR_CFG0, 32'h0);
			wait_st(ST_START, 4);
		end
		tally_and_finish();
	end

endmodule : tb
